// ---- core/irl_learn_replay.sv ----
// Infrared waveform learn and replay engine with an APB register slave.
// Assumes receiver input synchronous-safe via internal synchroniser, DMA
// stream source for replay words, and one core clock with sync reset.
//
// Behaviour
// - Learning state codes run sequentially from zero, success then failure reasons.
// - Status query reads zero when the state is success.
// - Status query reads one while state code is below success.
// - Status query reads the state code itself above success.
// - Replay setup selects PWM pin output and halts capture until reinitialised.
// - Saved result holds carrier period, segment count and segment durations.
// - Each start request sends the waveform once, never repeating.
// - Every falling edge on the receiver input while learning (waiting or begun, not in send mode) is a capture event.
// - Each edge is timestamped; short intervals keep the carrier segment open.
// - Long interval closes carrier, stores the gap, starts a new carrier.
// - Segment index starts at zero, alternates types, ends as total count.
// - Smallest of the first N intervals becomes the carrier period.
// - Replay carrier uses the period from the first DMA word, duty one third by default.
// - Carrier segments drive the carrier, gap segments hold the output idle.
// - Replay takes words from a DMA stream, then raises a done event.
// - Buffer holds at most 100 segments; overflow ends learning in failure.
// - Fewer segments than the minimum ends in the too-few failure.
// - Learning ends on an over-threshold interval or a silent threshold.
// - Default gap threshold is 1.5 times the longest carrier cycle.
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module irl_learn_replay
  import irl_pkg::*;
#(
  parameter int unsigned MAX_SEG        = irl_pkg::IRL_MAX_SEG,
  parameter int unsigned MIN_SEG        = irl_pkg::IRL_MIN_SEG,
  parameter int unsigned FINISH_TICKS   = irl_pkg::IRL_FINISH_TICKS,
  parameter int unsigned OVERTIME_TICKS = irl_pkg::IRL_OVERTIME_TICKS
)(
  input  wire logic        i_core_clk,
  input  wire logic        i_reset,
  input  wire logic        i_clk_en,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_receiver_input,
  output logic             o_emitter_output,
  output logic             o_pwm_mode,
  input  wire logic        i_dma_valid,
  input  wire logic [31:0] i_dma_data,
  input  wire logic        i_dma_last,
  output logic             o_dma_ready,
  output logic             o_replay_done
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                        sync1;
    logic                        sync2;
    logic                        sync3;
    logic [31:0]                 tick;
    irl_state_t                  state;
    logic                        send_mode;
    logic [31:0]                 start_t;
    logic [31:0]                 prev_t;
    logic [31:0]                 seg_t;
    logic [7:0]                  idx;
    logic [7:0]                  nsamp;
    logic [31:0]                 minp;
    logic [31:0]                 period;
    logic [7:0]                  count;
    logic [MAX_SEG-1:0][31:0]    seg_buf;
    logic [31:0]                 gap;
    logic [31:0]                 duty;
    logic [7:0]                  samples;
    logic [7:0]                  seg_sel;
    logic [31:0]                 rdata;
    irl_rp_t                     rp;
    logic [31:0]                 rperiod;
    logic [31:0]                 rhigh;
    logic [31:0]                 rdur;
    logic [31:0]                 rphase;
    logic                        rcarrier;
    logic                        rlast;
    logic                        done;
    logic                        emit;
  } irl_regs_t;

  irl_regs_t r;
  irl_regs_t n;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] elapsed(input logic [31:0] now, input logic [31:0] then_t);
    elapsed = now - then_t;
  endfunction

  function automatic logic [7:0] status_of(input irl_state_t s);
    if (s == IRL_ST_SUCCESS)
      status_of = 8'h00;
    else if (s < IRL_ST_SUCCESS)
      status_of = 8'h01;
    else
      status_of = 8'(s);
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a <= IRL_A_SAMPLES) && (a[1:0] == 2'b00);
  endfunction

  logic        wr;
  logic        fall;
  logic        capture_ok;
  logic [31:0] ivl;
  logic [7:0]  status_q;
  logic        cmd_init;
  logic        cmd_setup;
  logic        cmd_start;

  assign wr         = i_psel && i_penable && i_pwrite && mapped(i_paddr);
  assign cmd_init   = wr && (i_paddr == IRL_A_CTRL) && i_pwdata[IRL_B_INIT];
  assign cmd_setup  = wr && (i_paddr == IRL_A_CTRL) && i_pwdata[IRL_B_SETUP];
  assign cmd_start  = wr && (i_paddr == IRL_A_CTRL) && i_pwdata[IRL_B_START];
  assign fall       = r.sync3 && !r.sync2;
  assign ivl        = elapsed(r.tick, r.prev_t);
  assign capture_ok = !r.send_mode &&
                      (r.state == IRL_ST_WAITING || r.state == IRL_ST_BEGUN);
  assign status_q   = status_of(r.state);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    n       = r;
    n.sync1 = i_receiver_input;
    n.sync2 = r.sync1;
    n.sync3 = r.sync2;
    n.tick  = r.tick + 32'h0000_0001;
    n.done  = 1'b0;

    // Learning
    if (cmd_init)
    begin
      n.state     = IRL_ST_WAITING;
      n.send_mode = 1'b0;
      n.idx       = 8'h00;
      n.nsamp     = 8'h00;
      n.minp      = 32'hffff_ffff;
      n.start_t   = r.tick;
    end
    else if (capture_ok && r.state == IRL_ST_WAITING)
    begin
      if (fall)
      begin
        n.state  = IRL_ST_BEGUN;
        n.prev_t = r.tick;
        n.seg_t  = r.tick;
      end
      else if (elapsed(r.tick, r.start_t) > OVERTIME_TICKS)
        n.state = IRL_ST_FAIL_TIMEOUT;
    end
    else if (capture_ok)
    begin
      if (fall && ivl <= FINISH_TICKS)
      begin
        n.prev_t = r.tick;
        if (r.nsamp < r.samples)
        begin
          n.nsamp = r.nsamp + 8'h01;
          if (ivl < r.minp)
            n.minp = ivl;
        end
        if (ivl > r.gap)
        begin
          if ((9'(r.idx) + 9'h002) > 9'(MAX_SEG))
            n.state = IRL_ST_FAIL_FULL;
          else
          begin
            n.seg_buf[r.idx]          = r.prev_t - r.seg_t;
            n.seg_buf[r.idx + 8'h01]  = ivl;
            n.idx                     = r.idx + 8'h02;
            n.seg_t                   = r.tick;
          end
        end
      end
      else if (fall || ivl > FINISH_TICKS)
      begin
        // Closing edge or silence ends the frame; the closing edge is not kept
        if (9'(r.idx) >= 9'(MAX_SEG))
          n.state = IRL_ST_FAIL_FULL;
        else
        begin
          n.seg_buf[r.idx] = r.prev_t - r.seg_t;
          n.idx            = r.idx + 8'h01;
          n.count          = r.idx + 8'h01;
          n.period         = r.minp;
          if ((9'(r.idx) + 9'h001) < 9'(MIN_SEG))
            n.state = IRL_ST_FAIL_TOO_FEW;
          else
            n.state = IRL_ST_SUCCESS;
        end
      end
    end

    if (cmd_setup)
      n.send_mode = 1'b1;

    // Replay
    case (r.rp)
      IRL_RP_IDLE:
      begin
        if (cmd_start && r.send_mode)
          n.rp = IRL_RP_PERIOD;
      end
      IRL_RP_PERIOD:
      begin
        if (i_dma_valid)
        begin
          n.rperiod  = i_dma_data;
          n.rhigh    = (r.duty == 32'h0) ? i_dma_data / IRL_DUTY_DIV : r.duty;
          n.rcarrier = 1'b0;
          if (i_dma_last)
          begin
            n.rp   = IRL_RP_IDLE;
            n.done = 1'b1;
          end
          else
            n.rp = IRL_RP_FETCH;
        end
      end
      IRL_RP_FETCH:
      begin
        if (i_dma_valid)
        begin
          n.rdur     = i_dma_data;
          n.rlast    = i_dma_last;
          n.rcarrier = !r.rcarrier;
          n.rphase   = 32'h0;
          n.rp       = IRL_RP_RUN;
        end
      end
      IRL_RP_RUN:
      begin
        n.rdur = r.rdur - 32'h1;
        if ((r.rphase + 32'h1) >= r.rperiod)
          n.rphase = 32'h0;
        else
          n.rphase = r.rphase + 32'h1;
        if (r.rdur <= 32'h1)
        begin
          if (r.rlast)
          begin
            n.rp   = IRL_RP_IDLE;
            n.done = 1'b1;
          end
          else
            n.rp = IRL_RP_FETCH;
        end
      end
      default: n.rp = IRL_RP_IDLE;
    endcase
    // Gap segments and any idle time leave the emitter low
    n.emit = r.send_mode && (r.rp == IRL_RP_RUN) && (r.rdur != 32'h0) &&
             r.rcarrier && (r.rphase < r.rhigh);

    // Register writes
    if (wr)
    begin
      if (i_paddr == IRL_A_GAP)
        n.gap = i_pwdata;
      else if (i_paddr == IRL_A_DUTY)
        n.duty = i_pwdata;
      else if (i_paddr == IRL_A_SEG_SEL)
        n.seg_sel = i_pwdata[7:0];
      else if (i_paddr == IRL_A_SAMPLES)
        n.samples = i_pwdata[7:0];
    end

    // Read data captured in the setup phase, shown in the access phase
    if (i_psel && !i_penable)
    begin
      if (i_paddr == IRL_A_CTRL)
        n.rdata = {29'h0, r.done, (r.rp != IRL_RP_IDLE), r.send_mode};
      else if (i_paddr == IRL_A_STATUS)
        n.rdata = {24'h0, status_q};
      else if (i_paddr == IRL_A_STATE)
        n.rdata = {28'h0, r.state};
      else if (i_paddr == IRL_A_PERIOD)
        n.rdata = r.period;
      else if (i_paddr == IRL_A_COUNT)
        n.rdata = {24'h0, r.count};
      else if (i_paddr == IRL_A_GAP)
        n.rdata = r.gap;
      else if (i_paddr == IRL_A_DUTY)
        n.rdata = r.duty;
      else if (i_paddr == IRL_A_SEG_SEL)
        n.rdata = {24'h0, r.seg_sel};
      else if (i_paddr == IRL_A_SEG_DATA && 32'(r.seg_sel) < MAX_SEG)
        n.rdata = r.seg_buf[r.seg_sel];
      else if (i_paddr == IRL_A_SAMPLES)
        n.rdata = {24'h0, r.samples};
      else
        n.rdata = 32'h0;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      r         <= '0;
      r.minp    <= 32'hffff_ffff;
      r.gap     <= IRL_GAP_DEF;
      r.samples <= IRL_SAMPLES_DEF;
      r.sync1   <= 1'b1;
      r.sync2   <= 1'b1;
      r.sync3   <= 1'b1;
    end
    else if (i_clk_en)
      r <= n;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign o_prdata         = r.rdata;
  assign o_pready         = i_psel && i_penable;
  assign o_pslverr        = i_psel && i_penable && !mapped(i_paddr);
  assign o_emitter_output = r.emit;
  assign o_pwm_mode       = r.send_mode;
  assign o_dma_ready      = (r.rp == IRL_RP_PERIOD) || (r.rp == IRL_RP_FETCH);
  assign o_replay_done    = r.done;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_reset);

  property p_status_ok;
    (r.state == IRL_ST_SUCCESS) |-> (status_q == 8'h00);
  endproperty
  a_status_ok: assert property (p_status_ok) else $error("success not zero");

  property p_status_busy;
    (r.state < IRL_ST_SUCCESS) |-> (status_q == 8'h01);
  endproperty
  a_status_busy: assert property (p_status_busy) else $error("busy not one");

  property p_status_fail;
    (r.state > IRL_ST_SUCCESS) |-> (status_q == 8'(r.state)) && (status_q > 8'(IRL_ST_SUCCESS));
  endproperty
  a_status_fail: assert property (p_status_fail) else $error("bad fail code");

  property p_halt;
    (r.send_mode && !cmd_init) |=> $stable(r.state) && $stable(r.idx) && o_pwm_mode;
  endproperty
  a_halt: assert property (p_halt) else $error("capture ran in send mode");

  property p_once;
    o_replay_done |-> (r.rp == IRL_RP_IDLE) ##1 !o_replay_done;
  endproperty
  a_once: assert property (p_once) else $error("replay repeated");

  property p_first_edge;
    (i_clk_en && !cmd_init && fall && capture_ok && r.state == IRL_ST_WAITING)
      |=> (r.state == IRL_ST_BEGUN) && (r.prev_t == $past(r.tick));
  endproperty
  a_first_edge: assert property (p_first_edge) else $error("edge not captured");

  property p_gap;
    (i_clk_en && !cmd_init && fall && capture_ok && r.state == IRL_ST_BEGUN &&
     ivl > r.gap && ivl <= FINISH_TICKS && (9'(r.idx) + 9'h002) <= 9'(MAX_SEG))
      |=> (r.idx == $past(r.idx) + 8'h02) && (r.seg_t == $past(r.tick));
  endproperty
  a_gap: assert property (p_gap) else $error("gap not stored");

  property p_cap;
    9'(r.idx) <= 9'(MAX_SEG);
  endproperty
  a_cap: assert property (p_cap) else $error("buffer overrun");

  property p_idle_gap;
    (r.rp == IRL_RP_RUN && !r.rcarrier) |=> !o_emitter_output;
  endproperty
  a_idle_gap: assert property (p_idle_gap) else $error("carrier in gap");

  property p_ignore;
    (!capture_ok && !cmd_init) |=> $stable(r.idx) && $stable(r.prev_t);
  endproperty
  a_ignore: assert property (p_ignore) else $error("edge taken while idle");

  c_success: cover property (r.state == IRL_ST_BEGUN ##1 r.state == IRL_ST_SUCCESS);
  c_too_few: cover property (r.state == IRL_ST_FAIL_TOO_FEW);
  c_replay:  cover property (r.rp == IRL_RP_RUN ##[1:1000] o_replay_done);

endmodule

// ---- core/irl_pkg.sv ----
// Constants, register map and state codes of the infrared learn/replay engine.
// Assumes a 100 MHz core clock; every timing figure below derives from it.
package irl_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned IRL_CLK_HZ        = 100_000_000;
  localparam int unsigned IRL_MIN_FREQ_HZ   = 30_000;
  localparam int unsigned IRL_FINISH_MS     = 30;
  localparam int unsigned IRL_OVERTIME_MS   = 10_000;
  localparam int unsigned IRL_TICKS_PER_MS  = IRL_CLK_HZ / 1000;
  localparam int unsigned IRL_FINISH_TICKS  = IRL_FINISH_MS * IRL_TICKS_PER_MS;
  localparam int unsigned IRL_OVERTIME_TICKS = IRL_OVERTIME_MS * IRL_TICKS_PER_MS;
  // Longest supported carrier cycle, and the gap threshold at 1.5 times it
  localparam logic [31:0] IRL_MAX_CYCLE     = 32'(IRL_CLK_HZ / IRL_MIN_FREQ_HZ);
  localparam logic [31:0] IRL_GAP_DEF       = 32'((IRL_MAX_CYCLE * 3) / 2);

  // ---------------------------------------------------------------
  // Counts and defaults
  // ---------------------------------------------------------------
  localparam int unsigned IRL_MAX_SEG       = 100;
  localparam int unsigned IRL_MIN_SEG       = 15;
  localparam logic [7:0]  IRL_SAMPLES_DEF   = 8'h0a;
  localparam logic [31:0] IRL_DUTY_DIV      = 32'h0000_0003;

  // ---------------------------------------------------------------
  // Register map (byte addresses) and control bits
  // ---------------------------------------------------------------
  localparam logic [11:0] IRL_A_CTRL     = 12'h000;
  localparam logic [11:0] IRL_A_STATUS   = 12'h004;
  localparam logic [11:0] IRL_A_STATE    = 12'h008;
  localparam logic [11:0] IRL_A_PERIOD   = 12'h00c;
  localparam logic [11:0] IRL_A_COUNT    = 12'h010;
  localparam logic [11:0] IRL_A_GAP      = 12'h014;
  localparam logic [11:0] IRL_A_DUTY     = 12'h018;
  localparam logic [11:0] IRL_A_SEG_SEL  = 12'h01c;
  localparam logic [11:0] IRL_A_SEG_DATA = 12'h020;
  localparam logic [11:0] IRL_A_SAMPLES  = 12'h024;
  localparam int unsigned IRL_B_INIT     = 0;
  localparam int unsigned IRL_B_SETUP    = 1;
  localparam int unsigned IRL_B_START    = 2;

  // ---------------------------------------------------------------
  // Learning state codes, sequential from zero, and replay states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    IRL_ST_DISABLED,
    IRL_ST_WAITING,
    IRL_ST_KEY,
    IRL_ST_BEGUN,
    IRL_ST_SAMPLE_END,
    IRL_ST_SUCCESS,
    IRL_ST_FAIL_FIRST_LONG,
    IRL_ST_FAIL_TWO_GAPS,
    IRL_ST_FAIL_TIMEOUT,
    IRL_ST_FAIL_TOO_FEW,
    IRL_ST_FAIL_FULL,
    IRL_ST_FAIL
  } irl_state_t;

  typedef enum logic [1:0] {
    IRL_RP_IDLE,
    IRL_RP_PERIOD,
    IRL_RP_FETCH,
    IRL_RP_RUN
  } irl_rp_t;

endpackage

// ---- verif/irl_ir_partner.sv ----
// Behavioural receiver stage and emitter monitor for the learn/replay engine.
// Assumes burst is called just after a rising clock edge.
`timescale 1ns/1ps
module irl_ir_partner (
  input  wire logic i_core_clk,
  input  wire logic i_emitter_output,
  output logic      o_receiver_input
);
  int unsigned high_cycles = 0;
  int unsigned rises       = 0;
  logic        emit_q      = 1'b0;

  // ---------------------------------------------------------------
  // Receiver stage
  // ---------------------------------------------------------------
  // Pulled up at idle; each carrier pulse pulls the line low for a third of a period
  initial o_receiver_input = 1'b1;

  task automatic burst(input int n, input int p, input int w);
    repeat (n)
    begin
      o_receiver_input <= 1'b0;
      repeat (p / 3) @(posedge i_core_clk);
      o_receiver_input <= 1'b1;
      repeat (p - p / 3) @(posedge i_core_clk);
    end
    repeat (w) @(posedge i_core_clk);
  endtask

  // ---------------------------------------------------------------
  // Emitter monitor
  // ---------------------------------------------------------------
  always @(posedge i_core_clk)
  begin
    if (i_emitter_output === 1'b1) high_cycles++;
    if (i_emitter_output === 1'b1 && emit_q !== 1'b1) rises++;
    emit_q <= i_emitter_output;
  end
endmodule

// ---- verif/irl_learn_replay_tb.sv ----
// Self-checking bench of the learn/replay engine: APB master, DMA word source.
// Assumes short finish and overtime counts and a 20-segment buffer.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
module irl_learn_replay_tb;
  import irl_pkg::*;
  localparam int unsigned FIN  = 2000;
  localparam int unsigned OVT  = 5000;
  localparam int unsigned MAXS = 20;
  logic        core_clk  = 1'b0;
  logic        reset     = 1'b1;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [11:0] paddr     = 12'h000;
  logic [31:0] pwdata    = 32'h0;
  logic        dma_valid = 1'b0;
  logic [31:0] dma_data  = 32'h0;
  logic        dma_last  = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx;
  logic        emit;
  logic        pwm_mode;
  logic        dma_ready;
  logic        replay_done;
  logic [31:0] rd;
  logic        err;
  int          miscompares = 0;
  int          n_checks    = 0;
  int          done_cnt    = 0;
  int unsigned segs[$];
  int unsigned per;

  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (replay_done === 1'b1) done_cnt++;

  irl_learn_replay #(.MAX_SEG(MAXS), .FINISH_TICKS(FIN), .OVERTIME_TICKS(OVT)) dut (
    .i_core_clk(core_clk), .i_reset(reset), .i_clk_en(1'b1), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_receiver_input(rx),
    .o_emitter_output(emit), .o_pwm_mode(pwm_mode), .i_dma_valid(dma_valid),
    .i_dma_data(dma_data), .i_dma_last(dma_last), .o_dma_ready(dma_ready),
    .o_replay_done(replay_done));

  irl_ir_partner u_partner (.i_core_clk(core_clk), .i_emitter_output(emit),
    .o_receiver_input(rx));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic results();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
    begin
      $display("Result: passed");
    end
    else
    begin
      $display("Result: failed");
    end
    $finish;
  endtask

  function automatic logic [31:0] status_of(input logic [31:0] s);
    if (s == 32'(IRL_ST_SUCCESS)) return 32'h0;
    if (s < 32'(IRL_ST_SUCCESS)) return 32'h1;
    return s;
  endfunction

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    if (k == 50)
    begin
      miscompares++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic chk_reg(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask

  task automatic learn(input int nb, input irl_state_t st);
    int n;
    int w;
    segs.delete();
    per = 24 + $urandom % 17;
    apb(1'b1, IRL_A_CTRL, 32'h1);
    chk_reg(IRL_A_STATE, 32'(IRL_ST_WAITING), "state");
    for (int b = 0; b < nb; b++)
    begin
      n = 3 + $urandom % 4;
      w = (b == nb - 1) ? 0 : 100 + $urandom % 200;
      u_partner.burst(n, per, w);
      segs.push_back((n - 1) * per);
      if (b < nb - 1) segs.push_back(per + w);
    end
    repeat (FIN + 20) @(posedge core_clk);
    chk_reg(IRL_A_STATE, 32'(st), "state");
    chk_reg(IRL_A_STATUS, status_of(32'(st)), "status");
  endtask

  // Gap segments run up to a few hundred cycles before the next word is taken
  task automatic wait_ready();
    int k;
    for (k = 0; k < 1000; k++)
    begin
      @(posedge core_clk);
      if (dma_ready === 1'b1) break;
    end
    if (k == 1000)
    begin
      miscompares++;
      results();
    end
  endtask

  // Carrier segments are whole periods, so high time and pulse count are exact
  // Duty zero means a third of the period; a set duty must stay below it
  task automatic replay(input logic [31:0] duty);
    int k;
    int d0;
    int unsigned hi;
    int unsigned pulses;
    int unsigned hw;
    hi = 0;
    pulses = 0;
    hw = (duty == 32'h0) ? per / 3 : duty;
    d0 = done_cnt;
    u_partner.high_cycles = 0;
    u_partner.rises = 0;
    foreach (segs[i])
    begin
      if (i % 2 == 0)
      begin
        hi += segs[i] / per * hw;
        pulses += segs[i] / per;
      end
    end
    apb(1'b1, IRL_A_DUTY, duty);
    chk_reg(IRL_A_DUTY, duty, "duty");
    apb(1'b1, IRL_A_CTRL, 32'h4);
    dma_valid <= 1'b1;
    dma_last  <= 1'b0;
    dma_data  <= per;
    wait_ready();
    foreach (segs[i])
    begin
      dma_data <= segs[i];
      dma_last <= (i == segs.size() - 1);
      wait_ready();
    end
    dma_valid <= 1'b0;
    dma_last  <= 1'b0;
    for (k = 0; k < 5000 && done_cnt == d0; k++) @(posedge core_clk);
    if (done_cnt == d0)
    begin
      miscompares++;
      results();
    end
    repeat (300) @(posedge core_clk);
    `CHK("done pulses", d0 + 1, done_cnt)
    `CHK("carrier high cycles", hi, u_partner.high_cycles)
    `CHK("carrier pulses", pulses, u_partner.rises)
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h90c21579));
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    chk_reg(IRL_A_STATE, 32'h0, "state after reset");
    chk_reg(IRL_A_STATUS, 32'h1, "status after reset");
    chk_reg(IRL_A_GAP, IRL_GAP_DEF, "gap threshold");
    chk_reg(IRL_A_SAMPLES, {24'h0, IRL_SAMPLES_DEF}, "sample count");
    chk_reg(12'h028, 32'h0, "unmapped read");
    `CHK("unmapped error", 1'b1, err)
    // Edges before any init must leave the engine disabled
    u_partner.burst(4, 30, 0);
    repeat (FIN + 20) @(posedge core_clk);
    chk_reg(IRL_A_STATE, 32'h0, "state while disabled");
    apb(1'b1, IRL_A_GAP, 32'h64);
    learn(7, IRL_ST_FAIL_TOO_FEW);
    learn(12, IRL_ST_FAIL_FULL);
    apb(1'b1, IRL_A_CTRL, 32'h1);
    repeat (OVT + 20) @(posedge core_clk);
    chk_reg(IRL_A_STATUS, 32'(IRL_ST_FAIL_TIMEOUT), "status after timeout");
    learn(8, IRL_ST_SUCCESS);
    chk_reg(IRL_A_COUNT, 32'(segs.size()), "count");
    chk_reg(IRL_A_PERIOD, per, "period");
    foreach (segs[i])
    begin
      apb(1'b1, IRL_A_SEG_SEL, 32'(i));
      chk_reg(IRL_A_SEG_DATA, segs[i], "segment");
    end
    apb(1'b1, IRL_A_CTRL, 32'h2);
    `CHK("pwm mode", 1'b1, pwm_mode)
    chk_reg(IRL_A_CTRL, 32'h1, "control");
    u_partner.burst(8, per, 0);
    repeat (FIN + 20) @(posedge core_clk);
    chk_reg(IRL_A_STATE, 32'(IRL_ST_SUCCESS), "state in send mode");
    replay(32'h0);
    replay(32'(4 + $urandom % 8));
    apb(1'b1, IRL_A_CTRL, 32'h1);
    `CHK("pwm mode", 1'b0, pwm_mode)
    chk_reg(IRL_A_STATE, 32'(IRL_ST_WAITING), "state after init");
    // A start outside send mode must leave replay idle
    apb(1'b1, IRL_A_CTRL, 32'h4);
    chk_reg(IRL_A_CTRL, 32'h0, "start without setup");
    results();
  end
endmodule
